// ===== verilog/ppc_regs.sv
`timescale 1ns/1ps
module ppc_regs (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  input  wire logic [7:0]          addr,
  input  wire logic [7:0]          wdata,
  output logic      [7:0]          rdata,
  input  wire logic [2:0]          limit_strap_pin,
  input  wire logic                detection_enable,
  input  wire ppc_pkg::ppc_emu_t   emu,
  input  wire ppc_pkg::ppc_fault_t flt,
  input  wire logic                charge_update,
  input  wire logic [15:0]         charge_total,
  input  wire logic [1:0]          charge_quota_action,
  input  wire logic                charge_quota_clear,
  output logic                     charge_quota_flag,
  output logic [1:0]               quota_action_apply,
  output logic                     data_switch_closed,
  output logic [1:0]               drain_time_select,
  output logic [1:0]               plug_threshold_select,
  output logic [2:0]               current_cap_code,
  output logic                     test_limit_en,
  output logic                     port_power_on,
  output logic [1:0]               retry_test_volt_select,
  output logic                     short_detected
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ppc_pkg::ppc_regs_t  r;
    logic                strap_done;
    logic [2:0]          strap;
    logic                custom_lat;
    logic                host_lat;
    logic                flag;
    logic [1:0]          act;
    logic                dsw;
    ppc_pkg::ppc_rec_t   rec;
    logic                tst;
    logic                pwr;
    logic                shrt;
    logic [7:0]          rdata;
  } ppc_state_t;

  ppc_state_t s_q;
  ppc_state_t s_d;

  logic                      tmr_load;
  logic [ppc_pkg::TMR_W-1:0] tmr_count;
  logic                      tmr_done;
  logic [ppc_pkg::DELAY_W-1:0] delay_code;
  logic [ppc_pkg::SEL_W-1:0]   test_code;

  assign delay_code = s_q.r.retry[ppc_pkg::RET_DELAY_LSB +: ppc_pkg::DELAY_W];
  assign test_code  = s_q.r.retry[ppc_pkg::RET_TEST_LSB +: ppc_pkg::SEL_W];

  ppc_retry_timer u_tmr (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  function automatic logic [ppc_pkg::TMR_W-1:0] ms_to_cyc(input int ms);
    ms_to_cyc = ppc_pkg::TMR_W'(ms * ppc_pkg::MS_CYCLES);
  endfunction

  always_comb begin
    logic [7:0]              capw;
    logic [ppc_pkg::CAP_W-1:0] ceil;
    capw = '0;
    ceil = s_q.strap_done ? s_q.strap : limit_strap_pin;
    s_d = s_q;
    tmr_load = 1'b0;
    tmr_count = '0;
    s_d.shrt = 1'b0;

    // strap caught once after reset release, not under reset
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.strap = limit_strap_pin;
      s_d.r.cap = {5'h00, limit_strap_pin};
    end

    // ****************************************
    // register writes and reads
    // ****************************************
    if (wr_en) begin
      case (addr)
        ppc_pkg::ADDR_ATTACH: begin
          s_d.r.attach = (wdata & ppc_pkg::ATTACH_WMASK) | ppc_pkg::ATTACH_FIXED;
        end
        ppc_pkg::ADDR_CAP: begin
          capw = wdata & ppc_pkg::CAP_WMASK;
          // never above the strapped ceiling; the pin itself until it is latched
          s_d.r.cap = (capw[ppc_pkg::CAP_W-1:0] > ceil) ? {5'h00, ceil} : capw;
        end
        ppc_pkg::ADDR_LIM_HI: s_d.r.lim_hi = wdata;
        ppc_pkg::ADDR_LIM_LO: s_d.r.lim_lo = wdata;
        ppc_pkg::ADDR_RETRY: s_d.r.retry = wdata & ppc_pkg::RETRY_WMASK;
        ppc_pkg::ADDR_DSW: begin
          s_d.r.dsw = (wdata & ppc_pkg::DSW_WMASK) | ppc_pkg::DSW_FIXED;
        end
        default: begin
        end
      endcase
    end

    if (rd_en) begin
      case (addr)
        ppc_pkg::ADDR_ATTACH: s_d.rdata = s_q.r.attach;
        ppc_pkg::ADDR_CAP:    s_d.rdata = s_q.r.cap;
        ppc_pkg::ADDR_LIM_HI: s_d.rdata = s_q.r.lim_hi;
        ppc_pkg::ADDR_LIM_LO: s_d.rdata = s_q.r.lim_lo;
        ppc_pkg::ADDR_RETRY:  s_d.rdata = s_q.r.retry;
        ppc_pkg::ADDR_DSW:    s_d.rdata = s_q.r.dsw;
        default:              s_d.rdata = 8'h00;
      endcase
    end

    // ****************************************
    // charge quota
    // ****************************************
    if (charge_quota_clear) begin
      s_d.flag = 1'b0;
      s_d.act = 2'h0;
    end
    // set wins over clear
    if (charge_update && charge_total >= {s_q.r.lim_hi, s_q.r.lim_lo}) begin
      s_d.flag = 1'b1;
      s_d.act = charge_quota_action;
    end

    // ****************************************
    // data switch
    // ****************************************
    // custom and host bits latched at start so their mid-emulation edits wait for restart; detect and accept bits act at once
    if (emu.start) begin
      s_d.custom_lat = s_q.r.dsw[ppc_pkg::DSW_CUSTOM_BIT];
      s_d.host_lat = s_q.r.dsw[ppc_pkg::DSW_HOST_BIT];
    end
    s_d.dsw = (s_q.custom_lat && (emu.custom_phase || emu.custom_accept))
           || (s_q.host_lat && emu.host_phase)
           || (s_q.r.dsw[ppc_pkg::DSW_DETECT_BIT] && detection_enable
               && emu.detect_state)
           || (s_q.r.dsw[ppc_pkg::DSW_ACCEPT_BIT] && emu.dcp_accept
               && emu.active_state);

    // ****************************************
    // auto-recovery
    // ****************************************
    case (s_q.rec)
      ppc_pkg::PPC_RUN: begin
        if (flt.fault) begin
          s_d.rec = ppc_pkg::PPC_ERROR;
          s_d.pwr = 1'b0;
          tmr_load = 1'b1;
          tmr_count = ms_to_cyc(ppc_pkg::DELAY_BASE_MS
                      + ppc_pkg::DELAY_STEP_MS * int'(delay_code));
        end
      end
      ppc_pkg::PPC_ERROR: begin
        if (tmr_done) begin
          s_d.rec = ppc_pkg::PPC_CHECK;
        end
      end
      ppc_pkg::PPC_CHECK: begin
        if (!flt.over_temp && !flt.back_drive) begin
          s_d.rec = ppc_pkg::PPC_TEST;
          s_d.tst = 1'b1;
          s_d.pwr = 1'b1;
          tmr_load = 1'b1;
          tmr_count = ms_to_cyc(ppc_pkg::TEST_BASE_MS
                      + ppc_pkg::TEST_STEP_MS * int'(test_code));
        end
      end
      ppc_pkg::PPC_TEST: begin
        if (tmr_done) begin
          s_d.tst = 1'b0;
          if (!flt.vbus_ok) begin
            s_d.rec = ppc_pkg::PPC_ERROR;
            s_d.pwr = 1'b0;
            s_d.shrt = 1'b1;
            tmr_load = 1'b1;
            tmr_count = ms_to_cyc(ppc_pkg::DELAY_BASE_MS
                        + ppc_pkg::DELAY_STEP_MS * int'(delay_code));
          end else begin
            s_d.rec = ppc_pkg::PPC_RUN;
          end
        end
      end
      default: s_d.rec = ppc_pkg::PPC_RUN;
    endcase
  end

  // no sleep input: sleep leaves every flop untouched
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.r.attach <= ppc_pkg::ATTACH_RST;
      s_q.r.lim_hi <= ppc_pkg::LIM_RST;
      s_q.r.lim_lo <= ppc_pkg::LIM_RST;
      s_q.r.retry <= ppc_pkg::RETRY_RST;
      s_q.r.dsw <= ppc_pkg::DSW_RST;
      s_q.rec <= ppc_pkg::PPC_RUN;
      s_q.pwr <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign charge_quota_flag = s_q.flag;
  assign quota_action_apply = s_q.act;
  assign data_switch_closed = s_q.dsw;
  assign drain_time_select = s_q.r.attach[ppc_pkg::ATT_DRAIN_LSB +: ppc_pkg::SEL_W];
  assign plug_threshold_select = s_q.r.attach[ppc_pkg::ATT_PLUG_LSB +: ppc_pkg::SEL_W];
  assign current_cap_code = s_q.r.cap[ppc_pkg::CAP_W-1:0];
  assign test_limit_en = s_q.tst;
  assign port_power_on = s_q.pwr;
  assign retry_test_volt_select = s_q.r.retry[ppc_pkg::RET_VOLT_LSB +: ppc_pkg::SEL_W];
  assign short_detected = s_q.shrt;
endmodule

// ===== verilog/ppc_pkg.sv
package ppc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_ATTACH   = 8'h18;
  localparam logic [7:0] ADDR_CAP      = 8'h19;
  localparam logic [7:0] ADDR_LIM_HI   = 8'h1A;
  localparam logic [7:0] ADDR_LIM_LO   = 8'h1B;
  localparam logic [7:0] ADDR_RETRY    = 8'h1C;
  localparam logic [7:0] ADDR_DSW      = 8'h25;

  localparam logic [7:0] ATTACH_RST    = 8'h45;
  localparam logic [7:0] ATTACH_WMASK  = 8'h0F;
  localparam logic [7:0] ATTACH_FIXED  = 8'h40;
  localparam logic [7:0] DSW_RST       = 8'h14;
  localparam logic [7:0] DSW_WMASK     = 8'h0F;
  localparam logic [7:0] DSW_FIXED     = 8'h10;
  localparam logic [7:0] LIM_RST       = 8'hFF;
  localparam logic [7:0] RETRY_RST     = 8'h2A;
  localparam logic [7:0] RETRY_WMASK   = 8'h7F;
  localparam logic [7:0] CAP_WMASK     = 8'h07;

  localparam int ATT_DRAIN_LSB  = 2;
  localparam int ATT_PLUG_LSB   = 0;
  localparam int RET_DELAY_LSB  = 4;
  localparam int RET_TEST_LSB   = 2;
  localparam int RET_VOLT_LSB   = 0;
  localparam int DELAY_W        = 3;
  localparam int SEL_W          = 2;
  localparam int CAP_W          = 3;

  localparam int DSW_CUSTOM_BIT = 3;
  localparam int DSW_HOST_BIT   = 2;
  localparam int DSW_DETECT_BIT = 1;
  localparam int DSW_ACCEPT_BIT = 0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ        = 25_000_000;
  localparam int MS_CYCLES     = CLK_HZ / 1000;
  localparam int DELAY_BASE_MS = 15;
  localparam int DELAY_STEP_MS = 5;
  localparam int TEST_BASE_MS  = 10;
  localparam int TEST_STEP_MS  = 5;
  localparam int TMR_W         = 22;

  typedef enum logic [3:0] {
    PPC_RUN   = 4'h1,
    PPC_ERROR = 4'h2,
    PPC_CHECK = 4'h4,
    PPC_TEST  = 4'h8
  } ppc_rec_t;

  // phase of the external emulation sequencer
  typedef struct packed {
    logic start;
    logic custom_phase;
    logic custom_accept;
    logic host_phase;
    logic dcp_accept;
    logic detect_state;
    logic active_state;
  } ppc_emu_t;

  typedef struct packed {
    logic fault;
    logic over_temp;
    logic back_drive;
    logic vbus_ok;
  } ppc_fault_t;

  typedef struct packed {
    logic [7:0] attach;
    logic [7:0] cap;
    logic [7:0] lim_hi;
    logic [7:0] lim_lo;
    logic [7:0] retry;
    logic [7:0] dsw;
  } ppc_regs_t;
endpackage

// ===== verilog/ppc_retry_timer.sv
`timescale 1ns/1ps
module ppc_retry_timer (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              load,
  input  wire logic [ppc_pkg::TMR_W-1:0] count,
  output logic                   done
);
  typedef struct packed {
    logic [ppc_pkg::TMR_W-1:0] cnt;
    logic                      done;
  } ppc_tmr_t;

  ppc_tmr_t s_q;
  ppc_tmr_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (load) begin
      s_d.cnt = count;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
      s_d.done = (s_q.cnt == 1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
endmodule

// ===== tb/ppc_regs_props.sv
`timescale 1ns/1ps
module ppc_regs_props (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [2:0] limit_strap_pin,
  input wire logic [1:0] drain_time_select,
  input wire logic [1:0] plug_threshold_select,
  input wire logic [2:0] current_cap_code,
  input wire logic [1:0] retry_test_volt_select,
  input wire logic       short_detected
);
  // ****************************************
  // register bus checks and short pulse check
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] a);
    ce && wr_en && addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    ce && rd_en && addr == a;
  endsequence
  a_drain_follow: assert property (s_wr(8'h18) |=>
    drain_time_select == $past(wdata[3:2]))
    else $error("drain select wrong");
  a_plug_follow: assert property (s_wr(8'h18) |=>
    plug_threshold_select == $past(wdata[1:0]))
    else $error("plug select wrong");
  a_volt_follow: assert property (s_wr(8'h1C) |=>
    retry_test_volt_select == $past(wdata[1:0]))
    else $error("test volt select wrong");
  a_cap_write: assert property (s_wr(8'h19) ##0 wdata[2:0] <= limit_strap_pin
    |=> current_cap_code == $past(wdata[2:0])) else $error("cap write lost");
  a_cap_ceiling: assert property (current_cap_code <= limit_strap_pin)
    else $error("cap above strap");
  a_unmapped_zero: assert property (ce && rd_en && !(addr inside {[8'h18:8'h1C], 8'h25})
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  a_attach_fixed: assert property (s_rd(8'h18) |=> rdata[7:4] == 4'h4)
    else $error("attach reserved bits wrong");
  a_short_pulse: assert property (short_detected |=> !short_detected)
    else $error("short pulse too long");
endmodule
bind ppc_regs ppc_regs_props u_props (
  .mclk                   (mclk),
  .rst                    (rst),
  .ce                     (ce),
  .wr_en                  (wr_en),
  .rd_en                  (rd_en),
  .addr                   (addr),
  .wdata                  (wdata),
  .rdata                  (rdata),
  .limit_strap_pin        (limit_strap_pin),
  .drain_time_select      (drain_time_select),
  .plug_threshold_select  (plug_threshold_select),
  .current_cap_code       (current_cap_code),
  .retry_test_volt_select (retry_test_volt_select),
  .short_detected         (short_detected)
);

// ===== tb/ppc_host.sv
`timescale 1ns/1ps
module ppc_host (
  input  wire logic       mclk,
  output logic            wr_en,
  output logic            rd_en,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata
);
  initial begin
    wr_en = 0;
    rd_en = 0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // released bus shows inverted values so stale data never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 addr = a;
    wdata = d;
    wr_en = 1;
    @(posedge mclk);
    #1 wr_en = 0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1 addr = a;
    rd_en = 1;
    @(posedge mclk);
    #1 rd_en = 0;
    addr = ~a;
    d = rdata;
  endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic mclk = 0, rst = 1, ce = 1, detection_enable = 0, charge_update = 0, charge_quota_clear = 0;
  logic [2:0] limit_strap_pin = 3'h5;
  logic [15:0] charge_total = 16'h0000, t;
  logic [1:0] charge_quota_action = 2'h0;
  ppc_pkg::ppc_emu_t emu = '0;
  ppc_pkg::ppc_fault_t flt = 4'h1;
  wire logic wr_en, rd_en, charge_quota_flag, data_switch_closed, test_limit_en, port_power_on;
  wire logic short_detected;
  wire logic [7:0] addr, wdata, rdata;
  wire logic [1:0] quota_action_apply, drain_time_select, plug_threshold_select;
  wire logic [1:0] retry_test_volt_select;
  wire logic [2:0] current_cap_code;
  logic [7:0] v, d, a, ret;
  logic [7:0] ad[7] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h25, 8'h30};
  logic [7:0] rv[7] = '{8'h45, 8'h05, 8'hFF, 8'hFF, 8'h2A, 8'h14, 8'h00};
  int fails = 0, samples_checked = 0;
  logic [31:0] xs = 45;
  ppc_regs DUT (
    .mclk                   (mclk),
    .rst                    (rst),
    .ce                     (ce),
    .wr_en                  (wr_en),
    .rd_en                  (rd_en),
    .addr                   (addr),
    .wdata                  (wdata),
    .rdata                  (rdata),
    .limit_strap_pin        (limit_strap_pin),
    .detection_enable       (detection_enable),
    .emu                    (emu),
    .flt                    (flt),
    .charge_update          (charge_update),
    .charge_total           (charge_total),
    .charge_quota_action    (charge_quota_action),
    .charge_quota_clear     (charge_quota_clear),
    .charge_quota_flag      (charge_quota_flag),
    .quota_action_apply     (quota_action_apply),
    .data_switch_closed     (data_switch_closed),
    .drain_time_select      (drain_time_select),
    .plug_threshold_select  (plug_threshold_select),
    .current_cap_code       (current_cap_code),
    .test_limit_en          (test_limit_en),
    .port_power_on          (port_power_on),
    .retry_test_volt_select (retry_test_volt_select),
    .short_detected         (short_detected)
  );
  ppc_host h (
    .mclk  (mclk),
    .wr_en (wr_en),
    .rd_en (rd_en),
    .addr  (addr),
    .wdata (wdata),
    .rdata (rdata)
  );
  initial begin
    forever #20 mclk = ~mclk;
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] rnd();
    xs ^= xs << 13;
    xs ^= xs >> 17;
    xs ^= xs << 5;
    return xs[7:0];
  endfunction
  function automatic logic [7:0] expv(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h18: expv = {4'h4, d[3:0]};
      8'h19: expv = {5'h00, (d[2:0] > limit_strap_pin) ? limit_strap_pin : d[2:0]};
      8'h1C: expv = {1'b0, d[6:0]};
      8'h25: expv = {4'h1, d[3:0]};
      8'h1A, 8'h1B: expv = d;
      default: expv = 8'h00;
    endcase
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic sw(input logic [6:0] e, input logic x);
    emu = e;
    wt(3);
    chk("data switch", {7'h00, data_switch_closed}, {7'h00, x});
  endtask
  task automatic conclude();
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #2_000_000;
    fails++;
    conclude();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    wt(2);
    rst = 0;
    for (int i = 0; i < 7; i++) begin
      h.rd(ad[i], v);
      chk("reset value", v, rv[i]);
    end
    for (int i = 0; i < 36; i++) begin
      a = ad[i % 7];
      d = rnd();
      if (a == 8'h18) d = {4'h4, d[3:0]};
      if (i == 1) d = 8'hFF;
      h.wr(a, d);
      h.rd(a, v);
      chk("readback", v, expv(a, d));
      if (a == 8'h18) chk("drain", {6'h00, drain_time_select}, {6'h00, d[3:2]});
      if (a == 8'h18) chk("plug", {6'h00, plug_threshold_select}, {6'h00, d[1:0]});
      if (a == 8'h19) chk("cap", {5'h00, current_cap_code}, expv(a, d));
      if (a == 8'h1C) ret = expv(a, d);
    end
    chk("test volt", {6'h00, retry_test_volt_select}, {6'h00, ret[1:0]});
    ce = 0;
    h.wr(8'h1C, 8'h00);
    ce = 1;
    h.rd(8'h1C, v);
    chk("frozen retry", v, ret);
    for (int i = 0; i < 4; i++) begin
      t = {rnd(), rnd()} | 16'h0001;
      charge_quota_action = t[2:1];
      h.wr(8'h1A, t[15:8]);
      h.wr(8'h1B, t[7:0]);
      for (int k = 0; k < 2; k++) begin
        charge_total = t - 16'(1 - k);
        charge_update = 1;
        wt(1);
        charge_update = 0;
        wt(2);
        chk("quota flag", {7'h00, charge_quota_flag}, 8'(k));
        chk("quota action", {6'h00, quota_action_apply}, {6'h00, t[2:1] & {2{k[0]}}});
      end
      charge_quota_clear = 1;
      wt(1);
      charge_quota_clear = 0;
      wt(2);
    end
    // update at the threshold in the same cycle as a clear
    charge_total = t;
    charge_update = 1;
    charge_quota_clear = 1;
    wt(1);
    charge_update = 0;
    charge_quota_clear = 0;
    wt(2);
    chk("quota set wins", {7'h00, charge_quota_flag}, 8'h01);
    charge_quota_clear = 1;
    wt(1);
    charge_quota_clear = 0;
    wt(2);
    chk("quota cleared", {7'h00, charge_quota_flag}, 8'h00);
    h.wr(8'h25, 8'h02);
    detection_enable = 1;
    sw(7'h02, 1);
    detection_enable = 0;
    sw(7'h02, 0);
    h.wr(8'h25, 8'h04);
    sw(7'h48, 1);
    sw(7'h08, 1);
    h.wr(8'h25, 8'h00);
    sw(7'h08, 1);
    h.wr(8'h25, 8'h08);
    sw(7'h60, 1);
    sw(7'h10, 1);
    sw(7'h08, 0);
    h.wr(8'h25, 8'h01);
    sw(7'h01, 0);
    sw(7'h05, 1);
    sw(7'h04, 0);
    chk("power on", {7'h00, port_power_on}, 8'h01);
    // fault drops power; the delay itself is far beyond the run length
    flt = 4'h9;
    wt(2);
    chk("power off in error", {7'h00, port_power_on}, 8'h00);
    chk("test limit idle", {7'h00, test_limit_en}, 8'h00);
    chk("short idle", {7'h00, short_detected}, 8'h00);
    rst = 1;
    wt(1);
    flt = 4'h1;
    rst = 0;
    chk("power after reset", {7'h00, port_power_on}, 8'h01);
    h.rd(8'h1C, v);
    chk("retry after reset", v, 8'h2A);
    h.rd(8'h19, v);
    chk("cap after reset", v, {5'h00, limit_strap_pin});
    conclude();
  end
endmodule
